// >>> rtl/mbs_cfg.svh
// Constants of the serial register-protocol slave: codes, offsets, reset values and timing.
`ifndef MBS_CFG_SVH
`define MBS_CFG_SVH
`define MBS_FN_READ      8'h03
`define MBS_FN_WRITE     8'h06
`define MBS_REG_NODE     16'h0006
`define MBS_NODE_RST     16'h0001
`define MBS_CRC_INIT     16'hFFFF
`define MBS_CRC_POLY     16'hA001
`define MBS_FRAME_LEN    4'h8
`define MBS_MAX_QTY      16'h007D
`define MBS_REG_DEPTH    256
`define MBS_CLK_NS       40
`define MBS_GAP_NS       4010000
`define MBS_GAP_CYCLES   ((`MBS_GAP_NS + `MBS_CLK_NS - 1) / `MBS_CLK_NS)
`endif

// >>> rtl/mbs_pkg.sv
// Types shared by the protocol slave and its holding-register memory.
package mbs_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_TXH  = 3'b010,
		ST_RD   = 3'b011,
		ST_TXD  = 3'b100,
		ST_TXC  = 3'b101,
		ST_ECHO = 3'b110
	} mbs_st_e;

	typedef struct packed {
		logic        en;
		logic [15:0] addr;
		logic [15:0] data;
	} mbs_wr_s;

	typedef struct packed {
		mbs_st_e         st;
		logic [7:0][7:0] frm;
		logic [3:0]      cnt;
		logic            bad;
		logic [23:0]     gap;
		logic [15:0]     crc;
		logic [15:0]     node;
		logic [2:0]      ptr;
		logic            phase;
		logic [15:0]     raddr;
		logic [7:0]      rleft;
		logic [1:0][7:0] buf_b;
		logic [1:0]      bcnt;
		mbs_wr_s         wev;
		logic            drop;
	} mbs_state_s;
endpackage : mbs_pkg

// >>> rtl/mbs_regfile.sv
// Holding-register memory with one write port and a registered read port.
`timescale 1ns/1ps
`include "mbs_cfg.svh"
module mbs_regfile #(
	parameter int DEPTH = `MBS_REG_DEPTH,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic           core_clk,
	input  wire logic           reset_n,
	input  mbs_pkg::mbs_wr_s    wr,
	input  wire logic           rd_en,
	input  wire logic [AW-1:0]  rd_addr,
	output logic      [15:0]    rd_data
);
	if (DEPTH < 2 || AW != $clog2(DEPTH)) begin : g_chk_size
		$error("AW must be the address width of DEPTH");
	end

	logic [15:0] mem [DEPTH];
	logic [15:0] rd_q;

	always_ff @(posedge core_clk) begin
		if (wr.en) begin
			mem[wr.addr[AW-1:0]] <= wr.data;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_q <= 16'h0000;
		end else if (rd_en) begin
			rd_q <= mem[rd_addr];
		end
	end

	assign rd_data = rd_q;
endmodule : mbs_regfile

// >>> rtl/mbs_slave.sv
// Frame interpreter of a serial register-protocol slave: read-many and write-one requests.
// Notes on behaviour
// - Request is address, function, start, value, CRC.
// - Two-byte fields other than the CRC travel high byte first.
// - Node address lives in holding register 6.
// - Function 03 returns consecutive registers from start.
// - Read reply: node, 03, twice count, data, CRC.
// - Function 06 writes one register.
// - Valid write is echoed back unchanged.
// - Answer only own address; reply carries it.
// - Reply starts at once after request ends.
// - Damaged or missing bytes give no reply.
// - Table CRC-16 over frame, initialised all ones.
`timescale 1ns/1ps
`include "mbs_cfg.svh"
module mbs_slave #(
	parameter int DEPTH      = `MBS_REG_DEPTH,
	parameter int GAP_CYCLES = `MBS_GAP_CYCLES
) (
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic         rx_valid,
	input  wire logic [7:0]   rx_data,
	input  wire logic         rx_err,
	output logic              tx_valid,
	output logic      [7:0]   tx_data,
	input  wire logic         tx_ready,
	output logic      [15:0]  node_addr,
	output mbs_pkg::mbs_wr_s  reg_write,
	output logic              frame_drop,
	output logic              busy
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 7 || DEPTH > 65536) begin : g_chk_depth
		$error("DEPTH must hold register 6 and fit a 16-bit address");
	end
	if (GAP_CYCLES < 1 || GAP_CYCLES > 24'hFF_FFFF) begin : g_chk_gap
		$error("GAP_CYCLES must fit the 24-bit idle counter");
	end

	mbs_pkg::mbs_state_s q;
	mbs_pkg::mbs_state_s d;
	mbs_pkg::mbs_wr_s    wr;
	logic                rd_en;
	logic [15:0]         rd_data;
	logic                push;
	logic                pop;
	logic                space;
	logic [7:0]          pbyte;
	logic [15:0]         req_addr;
	logic [15:0]         req_qty;
	logic [15:0]         rdval;
	logic                ok_frame;
	logic                ok_rd;
	logic                ok_wr;
	logic [1:0]          nb;
	logic                lands;

	// Bitwise form of the table-driven CRC; the low byte of the result goes out first.
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_upd

	mbs_regfile #(
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_regs (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.wr       (wr),
		.rd_en    (rd_en),
		.rd_addr  (q.raddr[AW-1:0]),
		.rd_data  (rd_data)
	);

	assign req_addr = {q.frm[2], q.frm[3]};
	assign req_qty  = {q.frm[4], q.frm[5]};
	assign ok_frame = !q.bad && q.cnt == `MBS_FRAME_LEN && q.crc == 16'h0000
		&& q.frm[0] == q.node[7:0];
	assign ok_rd    = q.frm[1] == `MBS_FN_READ && req_qty != 16'h0000
		&& req_qty <= `MBS_MAX_QTY
		&& ({1'b0, req_addr} + {1'b0, req_qty}) <= 17'(DEPTH);
	assign ok_wr    = q.frm[1] == `MBS_FN_WRITE && {1'b0, req_addr} < 17'(DEPTH);
	assign rdval    = (q.raddr == `MBS_REG_NODE) ? q.node : rd_data;
	assign pop      = tx_valid && tx_ready;
	assign space    = (q.bcnt != 2'd2) || tx_ready;
	// A pushed byte that goes straight to the head of the buffer is on tx_data next cycle.
	assign lands    = push && (q.bcnt == 2'd0 || (q.bcnt == 2'd1 && pop));

	always_comb begin
		d      = q;
		push   = 1'b0;
		pbyte  = 8'h00;
		rd_en  = 1'b0;
		wr     = '0;
		nb     = 2'd0;
		d.wev  = '0;
		d.drop = 1'b0;
		unique case (q.st)
			mbs_pkg::ST_IDLE: begin
				if (rx_valid) begin
					d.frm[0] = rx_data;
					d.cnt    = 4'h1;
					d.bad    = rx_err;
					d.crc    = crc_upd(`MBS_CRC_INIT, rx_data);
					d.gap    = 24'h00_0000;
					d.st     = mbs_pkg::ST_RX;
				end
			end
			mbs_pkg::ST_RX: begin
				if (rx_valid) begin
					d.gap = 24'h00_0000;
					if (q.cnt < `MBS_FRAME_LEN) begin
						d.frm[q.cnt[2:0]] = rx_data;
						d.crc = crc_upd(q.crc, rx_data);
						d.cnt = q.cnt + 4'h1;
					end else begin
						d.bad = 1'b1;
					end
					if (rx_err) begin
						d.bad = 1'b1;
					end
				end else if (q.gap == 24'(GAP_CYCLES - 1)) begin
					if (ok_frame && ok_rd) begin
						d.st    = mbs_pkg::ST_TXH;
						d.ptr   = 3'd0;
						d.raddr = req_addr;
						d.rleft = req_qty[7:0];
						d.crc   = `MBS_CRC_INIT;
					end else if (ok_frame && ok_wr) begin
						wr.en   = 1'b1;
						wr.addr = req_addr;
						wr.data = req_qty;
						d.wev   = wr;
						if (req_addr == `MBS_REG_NODE) begin
							d.node = req_qty;
						end
						d.st  = mbs_pkg::ST_ECHO;
						d.ptr = 3'd0;
					end else begin
						d.drop = 1'b1;
						d.st   = mbs_pkg::ST_IDLE;
					end
				end else begin
					d.gap = q.gap + 24'h00_0001;
				end
			end
			mbs_pkg::ST_TXH: begin
				pbyte = (q.ptr == 3'd0) ? q.node[7:0] :
					(q.ptr == 3'd1) ? `MBS_FN_READ : {q.rleft[6:0], 1'b0};
				if (space) begin
					push  = 1'b1;
					d.crc = crc_upd(q.crc, pbyte);
					d.ptr = q.ptr + 3'd1;
					if (q.ptr == 3'd2) begin
						d.st = mbs_pkg::ST_RD;
					end
				end
			end
			mbs_pkg::ST_RD: begin
				rd_en   = 1'b1;
				d.phase = 1'b0;
				d.st    = mbs_pkg::ST_TXD;
			end
			mbs_pkg::ST_TXD: begin
				pbyte = q.phase ? rdval[7:0] : rdval[15:8];
				if (space) begin
					push    = 1'b1;
					d.crc   = crc_upd(q.crc, pbyte);
					d.phase = 1'b1;
					if (q.phase) begin
						d.raddr = q.raddr + 16'h0001;
						d.rleft = q.rleft - 8'h01;
						d.ptr   = 3'd0;
						d.st    = (q.rleft == 8'h01) ? mbs_pkg::ST_TXC : mbs_pkg::ST_RD;
					end
				end
			end
			mbs_pkg::ST_TXC: begin
				pbyte = q.ptr[0] ? q.crc[15:8] : q.crc[7:0];
				if (space) begin
					push  = 1'b1;
					d.ptr = q.ptr + 3'd1;
					if (q.ptr[0]) begin
						d.st = mbs_pkg::ST_IDLE;
					end
				end
			end
			mbs_pkg::ST_ECHO: begin
				pbyte = q.frm[q.ptr];
				if (space) begin
					push  = 1'b1;
					d.ptr = q.ptr + 3'd1;
					if (q.ptr == 3'd7) begin
						d.st = mbs_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				d.st = mbs_pkg::ST_IDLE;
			end
		endcase
		// Two-entry output buffer: a receiver stall holds the interpreter, no byte is lost.
		nb = q.bcnt;
		if (pop) begin
			d.buf_b[0] = q.buf_b[1];
			nb         = q.bcnt - 2'd1;
		end
		if (push) begin
			d.buf_b[nb[0]] = pbyte;
			nb             = nb + 2'd1;
		end
		d.bcnt = nb;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			q      <= '0;
			q.st   <= mbs_pkg::ST_IDLE;
			q.node <= `MBS_NODE_RST;
		end else begin
			q <= d;
		end
	end

	assign tx_valid   = q.bcnt != 2'd0;
	assign tx_data    = q.buf_b[0];
	assign node_addr  = q.node;
	assign reg_write  = q.wev;
	assign frame_drop = q.drop;
	assign busy       = q.st != mbs_pkg::ST_IDLE;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	sequence s_eval;
		q.st == mbs_pkg::ST_RX && !rx_valid && q.gap == 24'(GAP_CYCLES - 1);
	endsequence
	sequence s_read_ok;
		s_eval ##0 ok_frame ##0 ok_rd;
	endsequence

	AST_READ_STARTS: assert property (s_read_ok |=> q.st == mbs_pkg::ST_TXH ##1 push)
		else $error("read reply did not start right after the request");
	AST_BAD_DROPPED: assert property (s_eval ##0 !ok_frame |=> frame_drop && !busy)
		else $error("damaged or foreign frame was not dropped");
	AST_FIRST_IS_NODE: assert property (lands && q.st == mbs_pkg::ST_TXH && q.ptr == 3'd0
		|=> tx_valid && tx_data == node_addr[7:0])
		else $error("reply does not open with the node address");
	AST_FUNC_READ: assert property (lands && q.st == mbs_pkg::ST_TXH && q.ptr == 3'd1
		|=> tx_valid && tx_data == `MBS_FN_READ)
		else $error("read reply carries the wrong function code");
	AST_BYTE_COUNT: assert property (s_read_ok |=> ##2 (pbyte == {req_qty[6:0], 1'b0}))
		else $error("byte count is not twice the register count");
	AST_NODE_UPDATE: assert property (reg_write.en && reg_write.addr == `MBS_REG_NODE
		|-> node_addr == reg_write.data)
		else $error("write to register 6 did not change the node address");
	AST_WRITE_ECHO: assert property (wr.en |=> q.st == mbs_pkg::ST_ECHO && q.ptr == 3'd0)
		else $error("single write is not followed by its echo");
	AST_ECHO_BYTES: assert property (lands && q.st == mbs_pkg::ST_ECHO
		|=> tx_valid && tx_data == $past(q.frm[q.ptr]))
		else $error("echo byte differs from the request");
	AST_CRC_LOW_FIRST: assert property (push && q.st == mbs_pkg::ST_TXC && !q.ptr[0]
		|=> pbyte == $past(q.crc[15:8]) || !push)
		else $error("CRC bytes are out of order");
	AST_NO_OVERFLOW: assert property (push |-> space)
		else $error("byte pushed into a full output buffer");
endmodule : mbs_slave

// >>> bench/mbs_master_model.sv
// Reply side of the network master: takes reply bytes at a prompt, slow or stalled pace.
`timescale 1ns/1ps
module mbs_master_model (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	input  wire logic [1:0] mode
);
	logic [7:0] got [$];
	logic       tog;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tog <= 1'b0;
		end else begin
			tog <= ~tog;
			if (tx_valid && tx_ready) begin
				got.push_back(tx_data);
			end
		end
	end

	// Mode 0 takes every byte, mode 1 every other cycle, mode 2 holds off.
	assign tx_ready = (mode == 2'h0) || ((mode == 2'h1) && tog);
endmodule : mbs_master_model

// >>> bench/testbench.sv
// Self-checking bench of the protocol slave with a reply-side master model.
`timescale 1ns/1ps
`include "mbs_cfg.svh"
module testbench;
	localparam int GAP = 20;
	logic             core_clk = 1'b0;
	logic             reset_n = 1'b0;
	logic             rx_valid = 1'b0;
	logic [7:0]       rx_data = 8'h00;
	logic             rx_err = 1'b0;
	logic             tx_valid;
	logic [7:0]       tx_data;
	logic             tx_ready;
	logic [15:0]      node_addr;
	mbs_pkg::mbs_wr_s reg_write;
	logic             frame_drop;
	logic             busy;
	logic [1:0]       mode = 2'h0;
	logic [15:0]      mem [256];
	logic [32:0]      wr_seen;
	int               n_drop;
	int               n_fail;
	int               n_tests;
	// Leading bit tells whether a reply is due.
	logic [48:0]      rows [9] = '{49'h1_0106_000A_1234, 49'h1_0106_000B_ABCD,
		49'h1_0103_000A_0002, 49'h0_0206_000A_5555, 49'h0_0104_000A_0001,
		49'h0_0103_000A_0000, 49'h0_0103_0000_007E, 49'h0_0106_0100_0001,
		49'h0_0103_00FF_0002};

	always #20 core_clk = ~core_clk;

	mbs_slave #(.DEPTH(256), .GAP_CYCLES(GAP)) dut_u (
		.core_clk(core_clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_err(rx_err), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.node_addr(node_addr), .reg_write(reg_write), .frame_drop(frame_drop), .busy(busy)
	);
	mbs_master_model mst_u (
		.core_clk(core_clk), .reset_n(reset_n), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .mode(mode)
	);

	always @(posedge core_clk) begin
		if (frame_drop === 1'b1)
			n_drop++;
		if (reg_write.en === 1'b1)
			wr_seen = reg_write;
	end

	task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s seen %h want %h", $time, msg, seen, exp);
		end
	endtask : check

	function automatic logic [15:0] crc16(input logic [7:0] b [$]);
		logic [15:0] c;
		c = `MBS_CRC_INIT;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ `MBS_CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : crc16

	task automatic send(input logic [7:0] q [$], input int err_at);
		foreach (q[i]) begin
			@(posedge core_clk);
			rx_valid <= 1'b1;
			rx_data  <= q[i];
			rx_err   <= (i == err_at);
			@(posedge core_clk);
			rx_valid <= 1'b0;
			rx_err   <= 1'b0;
		end
	endtask : send

	task automatic xact(input logic [48:0] fr, input logic [15:0] flip, input int err_at);
		logic [7:0]  q [$];
		logic [7:0]  exp [$];
		logic [15:0] c;
		logic [15:0] a;
		logic [15:0] v;
		logic [32:0] wexp;
		int          d0;
		int          w;
		for (int i = 5; i >= 0; i--)
			q.push_back(fr[i*8 +: 8]);
		a = fr[31:16];
		v = fr[15:0];
		c = crc16(q) ^ flip;
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		if (fr[48] && q[1] == `MBS_FN_WRITE) begin
			exp = q;
			mem[a[7:0]] = v;
		end else if (fr[48]) begin
			exp.push_back(q[0]);
			exp.push_back(q[1]);
			exp.push_back({v[6:0], 1'b0});
			for (int r = 0; r < int'(v); r++) begin
				exp.push_back(mem[int'(a) + r][15:8]);
				exp.push_back(mem[int'(a) + r][7:0]);
			end
			c = crc16(exp);
			exp.push_back(c[7:0]);
			exp.push_back(c[15:8]);
		end
		mst_u.got.delete();
		wr_seen = 33'h0_0000_0000;
		d0 = n_drop;
		send(q, err_at);
		w = 0;
		while ((busy !== 1'b0 || tx_valid !== 1'b0) && w < 2000) begin
			@(negedge core_clk);
			w++;
		end
		// Lets the registered drop pulse reach the monitor before it is counted.
		@(negedge core_clk);
		check(w < 2000, 1'b1, "reply late");
		check(mst_u.got.size(), exp.size(), "reply length");
		foreach (exp[i])
			check(mst_u.got[i], exp[i], "reply byte");
		check(n_drop - d0, !fr[48], "drop count");
		wexp = (fr[48] && q[1] == `MBS_FN_WRITE) ? {1'b1, a, v} : 33'h0_0000_0000;
		check(wr_seen, wexp, "write strobe");
	endtask : xact

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test

	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		$display("CHECK FAILED at %0t: run hung", $time);
		stop_test();
	end

	initial begin
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 9; i++)
			xact(rows[i], 16'h0000, -1);
		xact(49'h0_0106_000A_7777, 16'h0001, -1);
		xact(49'h0_0106_000A_7777, 16'h0000, 3);
		xact(49'h1_0106_0006_0005, 16'h0000, -1);
		check(node_addr, 16'h0005, "node");
		xact(49'h0_0103_000A_0001, 16'h0000, -1);
		mode <= 2'h2;
		fork
			begin
				repeat (GAP + 40) @(posedge core_clk);
				mode <= 2'h1;
			end
			xact(49'h1_0503_000A_0002, 16'h0000, -1);
		join
		mode <= 2'h0;
		xact(49'h1_0503_0006_0001, 16'h0000, -1);
		@(posedge core_clk);
		reset_n <= 1'b0;
		@(negedge core_clk);
		check({tx_valid, busy, frame_drop, reg_write.en, node_addr}, 20'h0_0001, "reset");
		@(posedge core_clk);
		reset_n <= 1'b1;
		mem[6] = 16'h0001;
		xact(49'h1_0103_0006_0001, 16'h0000, -1);
		stop_test();
	end
endmodule : testbench
